// ===== verilog/lcsg_gen.sv
// Purpose: group-wide control-signal generator for one logic array group
// Assumes: all pins synchronous to clk_sys; group clocks are edge strobes
// Notes: Avalon-MM slave answers every access one cycle after it appears
`timescale 1ns/10ps
`include "lcsg_regs.svh"
module lcsg_gen
  import lcsg_pkg::*;
#(
  parameter int NUM_CELLS = 10,
  parameter int NUM_EXT = 26,
  parameter int NUM_COL = 4,
  parameter int NUM_CH = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_COL-1:0] col_clk,
  input wire logic [NUM_EXT-1:0] ext_in,
  input wire logic [NUM_CELLS-1:0] fb_in,
  input wire logic [NUM_CELLS-1:0] cell_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output lcsg_ctl_t grp_ctl_q,
  output logic [NUM_CELLS-1:0] cell_b_eff_q
);

  localparam int NSRC = NUM_COL + NUM_EXT + NUM_CELLS;

  lcsg_cfg_t cfg_q [NUM_CH];
  logic [1:0] mode_q;
  logic [NUM_CH-1:0] lvl;
  logic [NSRC-1:0] src;
  logic clk1_prev_q;
  logic ena1_eff_q;
  logic ena2_eff_q;
  logic act1;
  logic act2;
  logic edge1;
  logic edge2;
  logic no_pushback;
  logic dual_edge;
  logic acc;
  logic wr_take;
  logic [31:0] rd_d;
  logic [3:0] wr_idx;

  // column clocks sit lowest so a select of 0..3 is a global line
  assign src = {fb_in, ext_in, col_clk};
  assign no_pushback = mode_q[`LCSG_F_NO_PUSHBACK];
  assign dual_edge = mode_q[`LCSG_F_DUAL_EDGE];

  // one selector per channel; any line, global or local, feeds any channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic OFF = (i == int'(LCSG_CH_ENA1)) ||
                           (i == int'(LCSG_CH_ENA2)) ||
                           (i == int'(LCSG_CH_ADDNSUB));
    lcsg_src_sel #(
      .NSRC(NSRC),
      .SELW(6),
      .OFF_LEVEL(OFF)
    ) u_sel (
      .clk_sys(clk_sys),
      .rst(rst),
      .src(src),
      .sel(cfg_q[i].sel),
      .invert(cfg_q[i].invert),
      .on(cfg_q[i].on),
      .level_q(lvl[i])
    );
  end

  // clock two follows clock one's source on the other edge in dual mode
  logic clk2_src;
  logic clk2_src_prev_q;
  logic fall1;
  logic fall2;
  assign fall1 = cfg_q[LCSG_CH_CLK1].fall;
  assign clk2_src = dual_edge ? lvl[LCSG_CH_CLK1] : lvl[LCSG_CH_CLK2];
  assign fall2 = dual_edge ? ~fall1 : cfg_q[LCSG_CH_CLK2].fall;
  assign act1 = lvl[LCSG_CH_CLK1] ^ fall1;
  assign act2 = clk2_src ^ fall2;
  assign edge1 = act1 && !(clk1_prev_q ^ fall1);
  assign edge2 = act2 && !(clk2_src_prev_q ^ fall2);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk1_prev_q <= 1'b0;
      clk2_src_prev_q <= 1'b0;
    end else begin
      clk1_prev_q <= lvl[LCSG_CH_CLK1];
      clk2_src_prev_q <= clk2_src;
    end
  end

  // enables are only retimed while the paired clock sits inactive, so a
  // strobe is never cut short by an enable that moves mid-pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ena1_eff_q <= 1'b1;
      ena2_eff_q <= 1'b1;
    end else begin
      if (!act1) begin
        ena1_eff_q <= lvl[LCSG_CH_ENA1];
      end
      if (!act2) begin
        ena2_eff_q <= lvl[LCSG_CH_ENA2];
      end
    end
  end

  // one bundle fans out unchanged to every cell
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      grp_ctl_q <= '0;
    end else begin
      grp_ctl_q.clk1_tick <= edge1 && ena1_eff_q;
      grp_ctl_q.clk2_tick <= edge2 && ena2_eff_q;
      grp_ctl_q.ena1 <= ena1_eff_q;
      grp_ctl_q.ena2 <= ena2_eff_q;
      grp_ctl_q.aclr2 <= lvl[LCSG_CH_ACLR2];
      grp_ctl_q.sclr <= lvl[LCSG_CH_SCLR];
      grp_ctl_q.sload <= lvl[LCSG_CH_SLOAD];
      grp_ctl_q.invert_io <= !no_pushback;
      if (!no_pushback) begin
        // preset becomes a clear on an inverted register
        grp_ctl_q.aclr1 <= lvl[LCSG_CH_ACLR1] |
                           lvl[LCSG_CH_ALOAD];
        grp_ctl_q.aload <= 1'b0;
        grp_ctl_q.aload_data <= 1'b0;
      end else begin
        grp_ctl_q.aclr1 <= lvl[LCSG_CH_ACLR1];
        grp_ctl_q.aload <= lvl[LCSG_CH_ALOAD];
        grp_ctl_q.aload_data <= 1'b1;
      end
      grp_ctl_q.addnsub <= lvl[LCSG_CH_ADDNSUB];
      grp_ctl_q.carry_in_first <= !lvl[LCSG_CH_ADDNSUB];
    end
  end

  // high select means add; low inverts every B bit of the group
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cell_b_eff_q <= '0;
    end else begin
      cell_b_eff_q <= lvl[LCSG_CH_ADDNSUB] ? cell_b : ~cell_b;
    end
  end

  // Avalon-MM slave: waitrequest drops for exactly one cycle per access
  assign acc = (avs_read || avs_write) && avs_waitrequest;
  assign wr_take = avs_write && !avs_waitrequest;
  assign wr_idx = avs_address[5:2];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= `LCSG_WAIT_RST;
    end else begin
      avs_waitrequest <= !acc;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (avs_address == `LCSG_OFS_MODE) begin
      rd_d[1:0] = mode_q;
    end else if (avs_address == `LCSG_OFS_STATUS) begin
      rd_d[12:0] = grp_ctl_q;
      rd_d[22:13] = lvl;
    end else if (avs_address[1:0] == 2'h0 && wr_idx <= `LCSG_CH_LAST) begin
      rd_d[8:0] = cfg_q[wr_idx];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc && avs_read) begin
      avs_readdata <= rd_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= `LCSG_MODE_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_q[i] <= `LCSG_CH_RST;
      end
    end else if (wr_take) begin
      if (avs_address == `LCSG_OFS_MODE && avs_byteenable[0]) begin
        mode_q <= avs_writedata[1:0];
      end else if (avs_address[1:0] == 2'h0 &&
                   wr_idx <= `LCSG_CH_LAST) begin
        if (avs_byteenable[0]) begin
          cfg_q[wr_idx][7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          cfg_q[wr_idx][8] <= avs_writedata[8];
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence one_wait_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence ena1_low_s;
    !ena1_eff_q;
  endsequence

  sequence ena2_low_s;
    !ena2_eff_q;
  endsequence

  bus_answer_a: assert property (req_s |=> one_wait_s)
    else $error("slave did not answer in one cycle");

  gate_clk1_a: assert property (
    grp_ctl_q.clk1_tick |-> $past(ena1_eff_q) && $past(edge1))
    else $error("clock one ticked while its enable was low");

  gate_clk2_a: assert property (
    grp_ctl_q.clk2_tick |-> $past(ena2_eff_q) && $past(edge2))
    else $error("clock two ticked without its own enable");

  ena_glitch_a: assert property (
    $changed(ena1_eff_q) |-> !$past(act1))
    else $error("enable one moved while clock one active");

  sub_carry_a: assert property (
    !lvl[LCSG_CH_ADDNSUB] |=> grp_ctl_q.carry_in_first &&
      cell_b_eff_q == ~$past(cell_b))
    else $error("subtract did not invert B or set carry");

  add_pass_a: assert property (
    lvl[LCSG_CH_ADDNSUB] |=> grp_ctl_q.addnsub &&
      !grp_ctl_q.carry_in_first && cell_b_eff_q == $past(cell_b))
    else $error("add select did not pass B through");

  preset_inv_a: assert property (
    !no_pushback && lvl[LCSG_CH_ALOAD] |=> grp_ctl_q.aclr1 &&
      grp_ctl_q.invert_io && !grp_ctl_q.aload)
    else $error("inverted preset did not assert clear");

  preset_aload_a: assert property (
    no_pushback && lvl[LCSG_CH_ALOAD] |=> grp_ctl_q.aload &&
      grp_ctl_q.aload_data && !grp_ctl_q.invert_io)
    else $error("load preset missing or data not high");

  dual_edge_a: assert property (
    dual_edge && $stable(mode_q) && $fell(lvl[LCSG_CH_CLK1]) &&
      !fall1 && ena2_eff_q |=> grp_ctl_q.clk2_tick)
    else $error("dual edge mode missed the second edge");

  ena2_glitch_a: assert property (
    $changed(ena2_eff_q) |-> !$past(act2))
    else $error("enable two moved while clock two active");

  stop_clk1_a: assert property (
    ena1_low_s |=> !grp_ctl_q.clk1_tick)
    else $error("clock one ran with its enable low");

  stop_clk2_a: assert property (
    ena2_low_s |=> !grp_ctl_q.clk2_tick)
    else $error("clock two ran with its enable low");

  carry_pair_a: assert property (
    !$past(rst) |-> grp_ctl_q.carry_in_first != grp_ctl_q.addnsub)
    else $error("carry in does not mirror the subtract select");

  aload_data_a: assert property (
    grp_ctl_q.aload |-> grp_ctl_q.aload_data && !grp_ctl_q.invert_io)
    else $error("load preset without high load data");

  pushback_excl_a: assert property (
    grp_ctl_q.invert_io |-> !grp_ctl_q.aload && !grp_ctl_q.aload_data)
    else $error("inverted preset also pulsed the load");

  tick_excl_a: assert property (
    $past(dual_edge) && $past(dual_edge, 2) |->
      !(grp_ctl_q.clk1_tick && grp_ctl_q.clk2_tick))
    else $error("both group clocks ticked in one cycle");

endmodule : lcsg_gen

// ===== verilog/lcsg_regs.svh
// Purpose: register offsets, field positions and reset values of the
//          group control-signal generator
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one word each
// Notes: channel words hold select, invert, on and edge fields
`ifndef LCSG_REGS_SVH
`define LCSG_REGS_SVH

`define LCSG_OFS_CH0 6'h00
`define LCSG_OFS_MODE 6'h28
`define LCSG_OFS_STATUS 6'h2C
`define LCSG_CH_LAST 4'h9

`define LCSG_F_SEL_LSB 0
`define LCSG_F_SEL_MSB 5
`define LCSG_F_INV 6
`define LCSG_F_ON 7
`define LCSG_F_FALL 8

`define LCSG_F_NO_PUSHBACK 0
`define LCSG_F_DUAL_EDGE 1

`define LCSG_CH_RST 9'h000
`define LCSG_MODE_RST 2'h0
`define LCSG_WAIT_RST 1'b1

`endif

// ===== verilog/lcsg_pkg.sv
// Purpose: types shared by the group control-signal generator
// Assumes: ten control channels, ten logic cells per group
// Notes: constants live in lcsg_regs.svh
package lcsg_pkg;

  typedef enum logic [3:0] {
    LCSG_CH_CLK1 = 4'h0,
    LCSG_CH_CLK2 = 4'h1,
    LCSG_CH_ENA1 = 4'h2,
    LCSG_CH_ENA2 = 4'h3,
    LCSG_CH_ACLR1 = 4'h4,
    LCSG_CH_ACLR2 = 4'h5,
    LCSG_CH_SCLR = 4'h6,
    LCSG_CH_ALOAD = 4'h7,
    LCSG_CH_SLOAD = 4'h8,
    LCSG_CH_ADDNSUB = 4'h9
  } lcsg_chan_t;

  typedef struct packed {
    logic fall;
    logic on;
    logic invert;
    logic [5:0] sel;
  } lcsg_cfg_t;

  typedef struct packed {
    logic clk1_tick;
    logic clk2_tick;
    logic ena1;
    logic ena2;
    logic aclr1;
    logic aclr2;
    logic sclr;
    logic aload;
    logic aload_data;
    logic sload;
    logic addnsub;
    logic invert_io;
    logic carry_in_first;
  } lcsg_ctl_t;

endpackage : lcsg_pkg

// ===== verilog/lcsg_src_sel.sv
// Purpose: picks one control source out of the group's input lines
// Assumes: sources already synchronous to clk_sys
// Notes: registered output; an out-of-range select reads as the invert bit
`timescale 1ns/10ps
module lcsg_src_sel #(
  parameter int NSRC = 40,
  parameter int SELW = 6,
  parameter logic OFF_LEVEL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NSRC-1:0] src,
  input wire logic [SELW-1:0] sel,
  input wire logic invert,
  input wire logic on,
  output logic level_q
);

  logic level_d;

  always_comb begin
    level_d = OFF_LEVEL;
    if (on) begin
      level_d = invert;
      if (int'(sel) < NSRC) begin
        level_d = src[sel] ^ invert;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_q <= OFF_LEVEL;
    end else begin
      level_q <= level_d;
    end
  end

endmodule : lcsg_src_sel

// ===== testbench/lcsg_far_model.sv
// Purpose: far side of the group, clock network plus user cells
// Assumes: bench asks for one-cycle pulse requests per column clock
// Notes: clocks stand still between pulses; cell feedback is one flop
`timescale 1ns/10ps
module lcsg_far_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] pulse_req,
  input wire logic [9:0] cell_q,
  output logic [3:0] col_clk,
  output logic [9:0] fb_in
);
  logic [3:0] hold_q;
  // each request gives a two-cycle high on the column clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      col_clk <= 4'h0;
      hold_q <= 4'h0;
    end else begin
      col_clk <= pulse_req | hold_q;
      hold_q <= pulse_req;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fb_in <= 10'h000;
    end else begin
      fb_in <= cell_q;
    end
  end
endmodule : lcsg_far_model

// ===== testbench/lcsg_gen_bench.sv
// Purpose: self-checking bench of the group control generator
// Assumes: one clock, Avalon-MM master in the bench
// Notes: ticks are counted over a window, not at a fixed cycle
`timescale 1ns/10ps
module lcsg_gen_bench
  import lcsg_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] col_clk, pulse_req = 4'h0;
  logic [25:0] ext_in = 26'h0000000;
  logic [9:0] fb_in, cell_b = 10'h000, cell_b_eff_q;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  lcsg_ctl_t grp_ctl_q;
  int n_mismatch = 0, total_checks = 0, c1, c2;
  always #5 clk_sys = ~clk_sys;
  lcsg_gen u_dut (.clk_sys(clk_sys), .rst(rst), .col_clk(col_clk),
    .ext_in(ext_in), .fb_in(fb_in), .cell_b(cell_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .grp_ctl_q(grp_ctl_q),
    .cell_b_eff_q(cell_b_eff_q));
  lcsg_far_model u_far (.clk_sys(clk_sys), .rst(rst),
    .pulse_req(pulse_req), .cell_q(cell_b_eff_q), .col_clk(col_clk),
    .fb_in(fb_in));
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle
  // request stands until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic pulse_ticks(input logic [3:0] line);
    c1 = 0;
    c2 = 0;
    pulse_req <= line;
    @(posedge clk_sys);
    pulse_req <= 4'h0;
    repeat (8) begin
      @(posedge clk_sys);
      c1 += (grp_ctl_q.clk1_tick === 1'b1);
      c2 += (grp_ctl_q.clk2_tick === 1'b1);
    end
  endtask : pulse_ticks
  task automatic t_reset;
    idle(3);
    chk(avs_waitrequest, 32'h1);
    chk({grp_ctl_q.ena1, grp_ctl_q.ena2, grp_ctl_q.addnsub}, 32'h7);
    bus(1'b1, 6'h30, 32'h1FF);
    bus(1'b0, 6'h30, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 6'h00, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_clock;
    bus(1'b1, 6'h00, 32'h80);
    bus(1'b1, 6'h08, 32'h84);
    ext_in[0] <= 1'b1;
    idle(4);
    pulse_ticks(4'h1);
    chk(c1, 32'h1);
    ext_in[0] <= 1'b0;
    idle(4);
    pulse_ticks(4'h1);
    chk(c1, 32'h0);
    ext_in[0] <= 1'b1;
    bus(1'b1, 6'h28, 32'h2);
    idle(4);
    pulse_ticks(4'h1);
    chk({c1[7:0], c2[7:0]}, 32'h0101);
    bus(1'b1, 6'h28, 32'h0);
    // clock two on falling edges of column line 2, gated by enable two
    bus(1'b1, 6'h04, 32'h182);
    bus(1'b1, 6'h0C, 32'h87);
    ext_in[0] <= 1'b0;
    ext_in[3] <= 1'b1;
    idle(4);
    pulse_ticks(4'h4);
    chk({c1[7:0], c2[7:0]}, 32'h0001);
    ext_in[0] <= 1'b1;
    ext_in[3] <= 1'b0;
    idle(4);
    pulse_ticks(4'h4);
    chk({c1[7:0], c2[7:0]}, 32'h0000);
  endtask : t_clock
  task automatic t_arith;
    bus(1'b1, 6'h24, 32'h85);
    cell_b <= 10'h2A5;
    ext_in[1] <= 1'b1;
    idle(4);
    chk({grp_ctl_q.carry_in_first, cell_b_eff_q}, 32'h2A5);
    ext_in[1] <= 1'b0;
    idle(4);
    chk({grp_ctl_q.carry_in_first, cell_b_eff_q}, 32'h55A);
  endtask : t_arith
  task automatic t_preset;
    bus(1'b1, 6'h1C, 32'h86);
    ext_in[2] <= 1'b1;
    idle(4);
    chk({grp_ctl_q.aclr1, grp_ctl_q.invert_io, grp_ctl_q.aload},
        32'h6);
    bus(1'b1, 6'h28, 32'h1);
    idle(4);
    chk({grp_ctl_q.invert_io, grp_ctl_q.aload, grp_ctl_q.aload_data},
        32'h3);
    bus(1'b0, 6'h28, 32'h0);
    chk(rd, 32'h1);
  endtask : t_preset
  task automatic t_sources;
    bus(1'b1, 6'h14, 32'h81);
    c1 = 0;
    pulse_req <= 4'h2;
    @(posedge clk_sys);
    pulse_req <= 4'h0;
    repeat (8) begin
      @(posedge clk_sys);
      c1 += (grp_ctl_q.aclr2 === 1'b1);
    end
    chk(c1, 32'h2);
    // sclr taken from feedback line 0, the first cell's output
    bus(1'b1, 6'h18, 32'h9E);
    ext_in[1] <= 1'b1;
    idle(6);
    chk(grp_ctl_q.sclr, 32'h1);
    ext_in[1] <= 1'b0;
    idle(6);
    chk(grp_ctl_q.sclr, 32'h0);
    // sync load from ext line 4, inverted, so a low line reads as high
    bus(1'b1, 6'h20, 32'h1C8);
    idle(4);
    chk(grp_ctl_q.sload, 32'h1);
    bus(1'b0, 6'h20, 32'h0);
    chk(rd, 32'h1C8);
    ext_in[4] <= 1'b1;
    idle(4);
    chk(grp_ctl_q.sload, 32'h0);
  endtask : t_sources
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_clock();
    t_arith();
    t_preset();
    t_sources();
    final_report();
  end
endmodule : lcsg_gen_bench
